// [verilog/dmc_engine.sv]
`timescale 1ns/1ps
module dmc_engine
    import dmc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [7:0]        reg_rdata,
    input  wire logic              tx_request,
    output logic                   mem_rd,
    output logic      [ADDR_W-1:0] mem_raddr,
    input  wire logic [7:0]        mem_rdata,
    output logic                   mem_wr,
    output logic      [ADDR_W-1:0] mem_waddr,
    output logic      [7:0]        mem_wdata,
    output logic                   irq_n
);

    ////////////////////////////////////////////////////////////////////////
    dmc_regs_s st_r;
    dmc_regs_s st_nxt;
    logic      ctrl_wr;
    logic      start;
    logic      abort;
    logic      last_now;
    logic [15:0] word_sum;
    logic [15:0] pad_sum;
    logic [7:0]  rd_mux;

    dmc_ptr_if ptr ();

    assign ptr.cur        = st_r.src;
    assign ptr.ring_start = st_r.rx_start;
    assign ptr.ring_end   = st_r.rx_end;

    dmc_ring_step u_step (.p(ptr.step));

    dmc_ones_add u_word (.a(st_r.acc), .b({st_r.hi, mem_rdata}), .sum(word_sum));
    dmc_ones_add u_pad (.a(st_r.acc), .b({st_r.hi, 8'h00}), .sum(pad_sum));

    assign ctrl_wr  = reg_we && (reg_addr == OFF_CONTROL);
    assign start    = ctrl_wr && reg_wdata[CTRL_GO_BIT] && (st_r.state == DMC_IDLE);
    assign abort    = ctrl_wr && !reg_wdata[CTRL_GO_BIT] && (st_r.state != DMC_IDLE);
    // the first byte never ends the job
    assign last_now = (st_r.src == st_r.src_end) && !st_r.first;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        case (reg_addr)
            OFF_SRC_START_LO: rd_mux = st_r.src_start[7:0];
            OFF_SRC_START_HI: rd_mux = {3'h0, st_r.src_start[12:8]};
            OFF_SRC_END_LO:   rd_mux = st_r.src_end[7:0];
            OFF_SRC_END_HI:   rd_mux = {3'h0, st_r.src_end[12:8]};
            OFF_DST_START_LO: rd_mux = st_r.dst_start[7:0];
            OFF_DST_START_HI: rd_mux = {3'h0, st_r.dst_start[12:8]};
            OFF_RX_START_LO:  rd_mux = st_r.rx_start[7:0];
            OFF_RX_START_HI:  rd_mux = {3'h0, st_r.rx_start[12:8]};
            OFF_RX_END_LO:    rd_mux = st_r.rx_end[7:0];
            OFF_RX_END_HI:    rd_mux = {3'h0, st_r.rx_end[12:8]};
            OFF_CSUM_LO:      rd_mux = st_r.csum[7:0];
            OFF_CSUM_HI:      rd_mux = st_r.csum[15:8];
            OFF_CONTROL:      rd_mux = 8'(({7'h00, st_r.go} << CTRL_GO_BIT)
                                     | ({7'h00, st_r.csum_sel} << CTRL_SEL_BIT)
                                     | ({7'h00, tx_request} << CTRL_TXREQ_BIT));
            OFF_IRQ_ENABLE:   rd_mux = 8'(({7'h00, st_r.gie} << IE_GLOBAL_BIT)
                                     | ({7'h00, st_r.dma_ie} << IE_DMA_BIT));
            OFF_IRQ_FLAG:     rd_mux = 8'({7'h00, st_r.done} << IF_DONE_BIT);
            default:          rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.rd     = 1'b0;
        st_nxt.wr     = 1'b0;
        st_nxt.dvalid = st_r.rd;
        st_nxt.rdata  = reg_re ? rd_mux : 8'h00;
        // interrupt follows flag and both enables
        st_nxt.irq_n  = !(st_r.done && st_r.dma_ie && st_r.gie);

        // pointer writes are taken at any time; the host keeps them still while busy
        if (reg_we)
        begin
            case (reg_addr)
                OFF_SRC_START_LO: st_nxt.src_start[7:0]  = reg_wdata;
                OFF_SRC_START_HI: st_nxt.src_start[12:8] = reg_wdata[4:0];
                OFF_SRC_END_LO:   st_nxt.src_end[7:0]    = reg_wdata;
                OFF_SRC_END_HI:   st_nxt.src_end[12:8]   = reg_wdata[4:0];
                OFF_DST_START_LO: st_nxt.dst_start[7:0]  = reg_wdata;
                OFF_DST_START_HI: st_nxt.dst_start[12:8] = reg_wdata[4:0];
                OFF_RX_START_LO:  st_nxt.rx_start[7:0]   = reg_wdata;
                OFF_RX_START_HI:  st_nxt.rx_start[12:8]  = reg_wdata[4:0];
                OFF_RX_END_LO:    st_nxt.rx_end[7:0]     = reg_wdata;
                OFF_RX_END_HI:    st_nxt.rx_end[12:8]    = reg_wdata[4:0];
                OFF_CONTROL:      st_nxt.csum_sel        = reg_wdata[CTRL_SEL_BIT];
                OFF_IRQ_ENABLE:
                begin
                    st_nxt.gie    = reg_wdata[IE_GLOBAL_BIT];
                    st_nxt.dma_ie = reg_wdata[IE_DMA_BIT];
                end
                // write one to clear; a same-cycle set below wins
                OFF_IRQ_FLAG:     if (reg_wdata[IF_DONE_BIT]) st_nxt.done = 1'b0;
                default:          ;
            endcase
        end

        // read data arrives one clock after the read strobe was out
        if (st_r.dvalid && st_r.mode_sum)
        begin
            // end-around accumulate; the first byte of a pair waits as the high half
            st_nxt.hi_pend = !st_r.hi_pend;
            if (st_r.hi_pend)
                st_nxt.acc = word_sum;
            else
                st_nxt.hi  = mem_rdata;
        end
        if (st_r.dvalid && !st_r.mode_sum)
        begin
            st_nxt.wr    = 1'b1;
            st_nxt.waddr = st_r.dst;
            st_nxt.wdata = mem_rdata;
            st_nxt.dst   = ADDR_W'(st_r.dst + 13'h0001);
        end

        unique case (st_r.state)
            DMC_IDLE:
            begin
                if (start)
                begin
                    st_nxt.go       = 1'b1;
                    st_nxt.mode_sum = reg_wdata[CTRL_SEL_BIT];
                    st_nxt.src      = st_r.src_start;
                    st_nxt.dst      = st_r.dst_start;
                    st_nxt.first    = 1'b1;
                    st_nxt.last     = 1'b0;
                    st_nxt.acc      = RST_CSUM;
                    st_nxt.hi_pend  = 1'b0;
                    if (reg_wdata[CTRL_SEL_BIT])
                        st_nxt.state = DMC_SUM;
                    else if (tx_request)
                        st_nxt.state = DMC_WAIT;
                    else
                        st_nxt.state = DMC_CRD;
                end
            end
            DMC_WAIT: if (!tx_request) st_nxt.state = DMC_CRD;
            DMC_CRD:
            begin
                if (st_r.last)
                begin
                    st_nxt.state = DMC_IDLE;
                    st_nxt.go    = 1'b0;
                    st_nxt.done  = 1'b1;
                end
                else
                begin
                    st_nxt.rd    = 1'b1;
                    st_nxt.raddr = st_r.src;
                    st_nxt.src   = ptr.next;
                    st_nxt.first = 1'b0;
                    st_nxt.last  = last_now;
                    st_nxt.state = DMC_CWR;
                end
            end
            // second clock of each copied byte
            DMC_CWR: st_nxt.state = DMC_CRD;
            DMC_SUM:
            begin
                st_nxt.rd    = 1'b1;
                st_nxt.raddr = st_r.src;
                st_nxt.src   = ptr.next;
                st_nxt.first = 1'b0;
                st_nxt.last  = last_now;
                // no timeout, only the end match or an abort stops it
                if (last_now)
                    st_nxt.state = DMC_SFIN;
            end
            DMC_SFIN:
            begin
                if (!st_r.rd && !st_r.dvalid)
                begin
                    // result stored, go cleared, done set
                    st_nxt.csum  = st_r.hi_pend ? ~pad_sum : ~st_r.acc;
                    st_nxt.state = DMC_IDLE;
                    st_nxt.go    = 1'b0;
                    st_nxt.done  = 1'b1;
                end
            end
        endcase

        if (abort)
        begin
            st_nxt.state  = DMC_IDLE;
            st_nxt.go     = 1'b0;
            st_nxt.rd     = 1'b0;
            st_nxt.wr     = 1'b0;
            st_nxt.dvalid = 1'b0;
            st_nxt.done   = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            st_r <= RST_REGS;
        else
            st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata;
    assign mem_rd    = st_r.rd;
    assign mem_raddr = st_r.raddr;
    assign mem_wr    = st_r.wr;
    assign mem_waddr = st_r.waddr;
    assign mem_wdata = st_r.wdata;
    assign irq_n     = st_r.irq_n;

    ////////////////////////////////////////////////////////////////////////
    property p_load_src;
        @(posedge core_clk) disable iff (rst)
        (start && !reg_wdata[CTRL_SEL_BIT] && !tx_request)
            |-> ##2 (mem_rd && mem_raddr == $past(st_r.src_start, 2));
    endproperty
    a_load_src: assert property (p_load_src)
        else $error("first read not at source start");

    property p_step;
        @(posedge core_clk) disable iff (rst)
        (st_r.state == DMC_SUM && st_r.src != st_r.rx_end && !abort)
            |=> (st_r.src == ADDR_W'($past(st_r.src) + 13'h0001));
    endproperty
    a_step: assert property (p_step)
        else $error("source pointer did not advance by one");

    property p_wrap;
        @(posedge core_clk) disable iff (rst)
        ((st_r.state == DMC_SUM || (st_r.state == DMC_CRD && !st_r.last)) && st_r.src == st_r.rx_end && !abort)
            |=> (st_r.src == $past(st_r.rx_start));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("source pointer did not wrap to ring start");

    property p_end;
        @(posedge core_clk) disable iff (rst)
        (st_r.state == DMC_SUM && !st_r.first && st_r.src == st_r.src_end && !abort)
            |=> (st_r.state == DMC_SFIN) ##1 !mem_rd;
    endproperty
    a_end: assert property (p_end)
        else $error("engine did not stop at source end");

    property p_first;
        @(posedge core_clk) disable iff (rst)
        (st_r.state == DMC_SUM && st_r.first && !abort) |=> (st_r.state == DMC_SUM);
    endproperty
    a_first: assert property (p_first)
        else $error("first byte ended the operation");

    property p_abort;
        @(posedge core_clk) disable iff (rst)
        abort |=> (st_r.state == DMC_IDLE && !mem_rd && !mem_wr && !st_r.go
                   && $stable(st_r.csum)) ##1 !mem_rd;
    endproperty
    a_abort: assert property (p_abort)
        else $error("cancel did not stop the engine cleanly");

    property p_dst;
        @(posedge core_clk) disable iff (rst)
        (mem_wr ##2 mem_wr) |-> (mem_waddr == ADDR_W'($past(mem_waddr, 2) + 13'h0001));
    endproperty
    a_dst: assert property (p_dst)
        else $error("destination not linear");

    property p_defer;
        @(posedge core_clk) disable iff (rst)
        (st_r.state == DMC_WAIT && tx_request && !abort) |=> (st_r.state == DMC_WAIT) ##1 !mem_rd;
    endproperty
    a_defer: assert property (p_defer)
        else $error("copy ran during a transmit request");

    property p_finish;
        @(posedge core_clk) disable iff (rst)
        ($past(st_r.go) && !st_r.go) |-> (st_r.done && st_r.state == DMC_IDLE);
    endproperty
    a_finish: assert property (p_finish)
        else $error("go fell without done");

    property p_copy_rate;
        @(posedge core_clk) disable iff (rst)
        (mem_rd && !st_r.mode_sum && !st_r.last && !abort) |-> ##1 !mem_rd ##1 (mem_rd || !st_r.go);
    endproperty
    a_copy_rate: assert property (p_copy_rate)
        else $error("copy not two clocks per byte");

    property p_sum_nowrite;
        @(posedge core_clk) disable iff (rst)
        (st_r.mode_sum && st_r.state != DMC_IDLE) |-> !mem_wr;
    endproperty
    a_sum_nowrite: assert property (p_sum_nowrite)
        else $error("checksum mode wrote memory");

    property p_sum_rate;
        @(posedge core_clk) disable iff (rst)
        (st_r.state == DMC_SUM && !abort) |=> mem_rd;
    endproperty
    a_sum_rate: assert property (p_sum_rate)
        else $error("checksum skipped a clock");

    property p_irq;
        @(posedge core_clk) disable iff (rst)
        (st_r.done && st_r.dma_ie && st_r.gie) |=> !irq_n;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not asserted");

    property p_go;
        @(posedge core_clk) disable iff (rst)
        start |=> (st_r.go && st_r.state != DMC_IDLE);
    endproperty
    a_go: assert property (p_go)
        else $error("go not set after start");

endmodule : dmc_engine

// [verilog/dmc_pkg.sv]
package dmc_pkg;

    localparam int ADDR_W  = 13;
    localparam int REG_AW  = 5;

    // register map, byte-wide registers
    localparam logic [REG_AW-1:0] OFF_SRC_START_LO = 5'h00;
    localparam logic [REG_AW-1:0] OFF_SRC_START_HI = 5'h01;
    localparam logic [REG_AW-1:0] OFF_SRC_END_LO   = 5'h02;
    localparam logic [REG_AW-1:0] OFF_SRC_END_HI   = 5'h03;
    localparam logic [REG_AW-1:0] OFF_DST_START_LO = 5'h04;
    localparam logic [REG_AW-1:0] OFF_DST_START_HI = 5'h05;
    localparam logic [REG_AW-1:0] OFF_RX_START_LO  = 5'h06;
    localparam logic [REG_AW-1:0] OFF_RX_START_HI  = 5'h07;
    localparam logic [REG_AW-1:0] OFF_RX_END_LO    = 5'h08;
    localparam logic [REG_AW-1:0] OFF_RX_END_HI    = 5'h09;
    localparam logic [REG_AW-1:0] OFF_CSUM_LO      = 5'h0a;
    localparam logic [REG_AW-1:0] OFF_CSUM_HI      = 5'h0b;
    localparam logic [REG_AW-1:0] OFF_CONTROL      = 5'h0c;
    localparam logic [REG_AW-1:0] OFF_IRQ_ENABLE   = 5'h0d;
    localparam logic [REG_AW-1:0] OFF_IRQ_FLAG     = 5'h0e;

    // field positions
    localparam int CTRL_GO_BIT    = 5;
    localparam int CTRL_SEL_BIT   = 4;
    localparam int CTRL_TXREQ_BIT = 3;
    localparam int IE_GLOBAL_BIT  = 7;
    localparam int IE_DMA_BIT     = 5;
    localparam int IF_DONE_BIT    = 5;

    // reset values
    localparam logic [ADDR_W-1:0] RST_PTR     = 13'h0000;
    localparam logic [ADDR_W-1:0] RST_RX_END  = 13'h1fff;
    localparam logic [15:0]       RST_CSUM    = 16'h0000;

    typedef enum logic [2:0] {
        DMC_IDLE = 3'b000,
        DMC_WAIT = 3'b001,
        DMC_CRD  = 3'b011,
        DMC_CWR  = 3'b010,
        DMC_SUM  = 3'b100,
        DMC_SFIN = 3'b101
    } dmc_state_e;

    typedef struct packed {
        dmc_state_e         state;
        logic               go;
        logic               csum_sel;
        logic               mode_sum;
        logic [ADDR_W-1:0]  src_start;
        logic [ADDR_W-1:0]  src_end;
        logic [ADDR_W-1:0]  dst_start;
        logic [ADDR_W-1:0]  rx_start;
        logic [ADDR_W-1:0]  rx_end;
        logic [15:0]        csum;
        logic               dma_ie;
        logic               gie;
        logic               done;
        logic [ADDR_W-1:0]  src;
        logic [ADDR_W-1:0]  dst;
        logic               first;
        logic               last;
        logic               rd;
        logic [ADDR_W-1:0]  raddr;
        logic               wr;
        logic [ADDR_W-1:0]  waddr;
        logic [7:0]         wdata;
        logic               dvalid;
        logic               hi_pend;
        logic [7:0]         hi;
        logic [15:0]        acc;
        logic [7:0]         rdata;
        logic               irq_n;
    } dmc_regs_s;

    localparam dmc_regs_s RST_REGS = '{
        state: DMC_IDLE, rx_end: RST_RX_END, csum: RST_CSUM, src_start: RST_PTR,
        src_end: RST_PTR, dst_start: RST_PTR, rx_start: RST_PTR, irq_n: 1'b1,
        acc: RST_CSUM, default: '0
    };

endpackage : dmc_pkg

// [verilog/dmc_ptr_if.sv]
`timescale 1ns/1ps
interface dmc_ptr_if;
    import dmc_pkg::*;
    logic [ADDR_W-1:0] cur;
    logic [ADDR_W-1:0] ring_start;
    logic [ADDR_W-1:0] ring_end;
    logic [ADDR_W-1:0] next;

    modport user (output cur, ring_start, ring_end, input next);
    modport step (input cur, ring_start, ring_end, output next);
endinterface : dmc_ptr_if

// [verilog/dmc_ring_step.sv]
`timescale 1ns/1ps
module dmc_ring_step
    import dmc_pkg::*;
(
    dmc_ptr_if.step p
);
    // the 13-bit sum wraps at the top of the buffer by itself
    assign p.next = (p.cur == p.ring_end) ? p.ring_start : ADDR_W'(p.cur + 13'h0001);
endmodule : dmc_ring_step

// [verilog/dmc_ones_add.sv]
`timescale 1ns/1ps
module dmc_ones_add
(
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    output wire logic [15:0] sum
);
    logic [16:0] raw;
    assign raw = {1'b0, a} + {1'b0, b};
    // end-around carry back into bit 0
    assign sum = 16'(raw[15:0] + {15'h0000, raw[16]});
endmodule : dmc_ones_add

// [verification/dmc_mem_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////
module dmc_mem_model
(
    input  wire logic        core_clk,
    input  wire logic        mem_rd,
    input  wire logic [12:0] mem_raddr,
    output logic      [7:0]  mem_rdata,
    input  wire logic        mem_wr,
    input  wire logic [12:0] mem_waddr,
    input  wire logic [7:0]  mem_wdata
);
    logic [7:0] mem [0:8191];
    initial mem_rdata = 8'h00;
    // data toggles outside the answer cycle so a late sample cannot pass
    always @(posedge core_clk)
    begin
        mem_rdata <= mem_rd ? mem[mem_raddr] : ~mem_rdata;
        if (mem_wr)
            mem[mem_waddr] <= mem_wdata;
    end
endmodule : dmc_mem_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
    import dmc_pkg::*;
    logic              core_clk, rst, reg_we, reg_re, tx_request, mem_rd, mem_wr, irq_n;
    logic [REG_AW-1:0] reg_addr;
    logic [7:0]        reg_wdata, reg_rdata, mem_rdata, mem_wdata;
    logic [ADDR_W-1:0] mem_raddr, mem_waddr, a;
    logic [15:0]       e;
    logic [31:0]       seed;
    logic [20:0]       wq[$];
    logic [7:0]        snap [0:8191];
    int                errors, checked, cyc, rd_n, last_rd, gap, n, m, i, j;

    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    dmc_engine u_dmc_engine (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .tx_request(tx_request), .mem_rd(mem_rd),
        .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .irq_n(irq_n));
    dmc_mem_model u_dmc_mem_model (.core_clk(core_clk), .mem_rd(mem_rd), .mem_raddr(mem_raddr),
        .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));
////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [15:0] csum_exp(input logic [12:0] s, input int len);
        int sum;
        sum = 0;
        for (int k = 0; k < len; k++)
            sum += k[0] ? snap[13'(s + k)] : {snap[13'(s + k)], 8'h00};
        // end-around carry folded until nothing is left above bit 15
        while (sum > 32'hffff)
            sum = (sum & 32'hffff) + (sum >> 16);
        return ~sum[15:0];
    endfunction : csum_exp

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [4:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        reg_we    <= 1'b1;
        reg_addr  <= ad;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] ad, input logic [7:0] exp);
        @(posedge core_clk);
        reg_re   <= 1'b1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1;
        check({16'h0, reg_rdata}, {16'h0, exp});
    endtask : rd

    task automatic setp(input logic [4:0] ad, input logic [12:0] p);
        wr(ad, p[7:0]);
        wr(ad + 5'h01, {3'h0, p[12:8]});
    endtask : setp

    task automatic start(input logic [7:0] ctrl, input int g);
        for (int k = 0; k < 8192; k++)
            snap[k] = u_dmc_mem_model.mem[k];
        rd_n = 0;
        gap  = g;
        wq.delete();
        wr(OFF_CONTROL, ctrl);
    endtask : start

    task automatic wait_irq;
        for (int k = 0; k < 400 && irq_n !== 1'b0; k++)
            @(posedge core_clk);
        #1;
        check({23'h0, irq_n}, 24'h0);
    endtask : wait_irq

    task automatic comp_copy(input logic [12:0] s, input logic [12:0] d, input logic [12:0] rs,
                             input logic [12:0] re);
        logic [12:0] p;
        p = s;
        foreach (wq[k])
        begin
            check(24'(wq[k]), {3'h0, 13'(d + k), snap[p]});
            p = (p == re) ? rs : p + 13'h0001;
        end
    endtask : comp_copy
////////////////////////////////////////
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 6000)
        begin
            errors++;
            give_verdict();
        end
        else
        begin
            if (mem_rd)
            begin
                if (rd_n > 0)
                    check(24'(cyc - last_rd), 24'(gap));
                rd_n++;
                last_rd = cyc;
            end
            if (mem_wr)
                wq.push_back({mem_waddr, mem_wdata});
        end
    end

    initial
    begin
        {rst, reg_we, reg_re, reg_addr, reg_wdata, tx_request} = '1;
        {reg_we, reg_re, reg_addr, reg_wdata, tx_request} = '0;
        {errors, checked, cyc, rd_n, last_rd, gap} = '0;
        seed = 32'h557aee9d;
        for (i = 0; i < 8192; i++)
        begin
            seed = lfsr(seed);
            u_dmc_mem_model.mem[i] = seed[7:0];
        end
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 15; i++)
            rd(i[4:0], i == 8 ? 8'hff : (i == 9 ? 8'h1f : 8'h00));
        wr(5'h1f, 8'hff);
        rd(5'h1f, 8'h00);
        wr(OFF_IRQ_ENABLE, 8'ha0);
        // copy: source wraps on the ring, destination wraps at the buffer top, start deferred by transmit
        setp(OFF_RX_START_LO, 13'h0100);
        setp(OFF_RX_END_LO, 13'h010f);
        setp(OFF_SRC_START_LO, 13'h010c);
        setp(OFF_SRC_END_LO, 13'h0102);
        setp(OFF_DST_START_LO, 13'h1ffd);
        tx_request <= 1'b1;
        start(8'h20, 2);
        repeat (10) @(posedge core_clk);
        rd(OFF_CONTROL, 8'h28);
        check(24'(rd_n), 24'h0);
        tx_request <= 1'b0;
        wait_irq();
        check(24'(rd_n), 24'h7);
        check(24'(wq.size()), 24'h7);
        comp_copy(13'h010c, 13'h1ffd, 13'h0100, 13'h010f);
        rd(OFF_CONTROL, 8'h00);
        rd(OFF_IRQ_FLAG, 8'h20);
        rd(OFF_SRC_END_LO, 8'h02);
        rd(OFF_CSUM_LO, 8'h00);
        wr(OFF_IRQ_FLAG, 8'h20);
        @(posedge core_clk);
        #1;
        check({23'h0, irq_n}, 24'h1);
        // checksum sweep over random ranges, odd and even lengths
        setp(OFF_RX_START_LO, 13'h0000);
        setp(OFF_RX_END_LO, 13'h1fff);
        for (j = 0; j < 6; j++)
        begin
            seed = lfsr(seed);
            a = (j == 0) ? 13'h0040 : {1'b0, seed[11:0]};
            // a one-byte range is start equal to end, which walks the whole buffer
            n = (j == 0) ? 3 : 2 + int'(seed[16:12]);
            if (j == 0)
                {u_dmc_mem_model.mem[64], u_dmc_mem_model.mem[65], u_dmc_mem_model.mem[66]} = 24'h89abcd;
            setp(OFF_SRC_START_LO, a);
            setp(OFF_SRC_END_LO, 13'(a + n - 1));
            tx_request <= j[0];
            start(8'h30, 1);
            wait_irq();
            check(24'(rd_n), 24'(n));
            check(24'(wq.size()), 24'h0);
            e = csum_exp(a, n);
            rd(OFF_CSUM_LO, e[7:0]);
            rd(OFF_CSUM_HI, e[15:8]);
            rd(OFF_CONTROL, {4'h1, j[0], 3'h0});
            wr(OFF_IRQ_ENABLE, 8'h20);
            @(posedge core_clk);
            #1;
            check({23'h0, irq_n}, 24'h1);
            wr(OFF_IRQ_ENABLE, 8'ha0);
            wr(OFF_IRQ_FLAG, 8'h20);
        end
        // start equal to end outside the ring: the walk enters the ring and never returns, so cancel it
        tx_request <= 1'b0;
        setp(OFF_RX_START_LO, 13'h0200);
        setp(OFF_RX_END_LO, 13'h020f);
        setp(OFF_SRC_START_LO, 13'h01f0);
        setp(OFF_SRC_END_LO, 13'h01f0);
        setp(OFF_DST_START_LO, 13'h0400);
        start(8'h20, 2);
        repeat (90) @(posedge core_clk);
        rd(OFF_CONTROL, 8'h20);
        check({23'h0, rd_n > 32}, 24'h1);
        wr(OFF_CONTROL, 8'h00);
        @(posedge core_clk);
        #1;
        n = rd_n;
        m = wq.size();
        repeat (10) @(posedge core_clk);
        check(24'(rd_n), 24'(n));
        check(24'(wq.size()), 24'(m));
        comp_copy(13'h01f0, 13'h0400, 13'h0200, 13'h020f);
        rd(OFF_IRQ_FLAG, 8'h20);
        rd(OFF_SRC_START_LO, 8'hf0);
        rd(OFF_CSUM_LO, e[7:0]);
        give_verdict();
    end
endmodule : tb
